//--- hdl/apm_pin_mux.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module apm_pin_mux (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pmaster_ok,
	input wire logic [apm_pkg::PIN_N-1:0] mux1_pin_in,
	input wire logic [apm_pkg::PIN_N-1:0] mux2_pin_in,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [apm_pkg::PIN_N-1:0] mux1_pin_out,
	output logic [apm_pkg::PIN_N-1:0] mux1_pin_oe,
	output logic [apm_pkg::PIN_N-1:0] mux1_analog_en,
	output logic [apm_pkg::PIN_N-1:0] mux2_pin_out,
	output logic [apm_pkg::PIN_N-1:0] mux2_pin_oe,
	output logic [apm_pkg::PIN_N-1:0] mux2_analog_en
);
	import apm_pkg::*;
	typedef struct packed {
		logic [31:0] rdata;
		logic rdy;
		logic err;
	} apm_bus_s;
	apm_bus_s bus_q, bus_d;
	logic setup, hit, wr_ok;
	logic w1s, w1d, w1r, w2s, w2d, w2r;
	logic [SEL_W-1:0] sel1, sel2;
	logic [DBIT_N-1:0] dat1, dat2, dir1, dir2, din1, din2;

	// transfer is taken in the setup cycle and answered with pready next cycle
	assign setup = psel & ~penable;
	assign hit = (paddr == M1_SEL_OFF) || (paddr == M1_DAT_OFF) || (paddr == M1_DIR_OFF) ||
		(paddr == M2_SEL_OFF) || (paddr == M2_DAT_OFF) || (paddr == M2_DIR_OFF);
	assign wr_ok = setup & pwrite & hit & pmaster_ok;
	assign w1s = wr_ok & (paddr == M1_SEL_OFF);
	assign w1d = wr_ok & (paddr == M1_DAT_OFF);
	assign w1r = wr_ok & (paddr == M1_DIR_OFF);
	assign w2s = wr_ok & (paddr == M2_SEL_OFF);
	assign w2d = wr_ok & (paddr == M2_DAT_OFF);
	assign w2r = wr_ok & (paddr == M2_DIR_OFF);

	always_comb begin
		bus_d = bus_q;
		bus_d.rdy = setup;
		bus_d.err = 1'b0;
		bus_d.rdata = 32'h0000_0000;
		if (setup) begin
			if (!hit || !pmaster_ok) begin
				bus_d.err = 1'b1;
			end else if (pwrite) begin
				bus_d.rdata = 32'h0000_0000;
			end else if (paddr == M1_SEL_OFF) begin
				bus_d.rdata = sel1;
			end else if (paddr == M1_DAT_OFF) begin
				// direction picks output latch or sampled pin, no pull-up field exists
				bus_d.rdata = {28'h000_0000, (dat1 & dir1) | (din1 & ~dir1)};
			end else if (paddr == M1_DIR_OFF) begin
				bus_d.rdata = {28'h000_0000, dir1};
			end else if (paddr == M2_SEL_OFF) begin
				bus_d.rdata = sel2;
			end else if (paddr == M2_DAT_OFF) begin
				bus_d.rdata = {28'h000_0000, (dat2 & dir2) | (din2 & ~dir2)};
			end else begin
				bus_d.rdata = {28'h000_0000, dir2};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q <= '{rdata: 32'h0000_0000, rdy: 1'b0, err: 1'b0};
		end else begin
			bus_q <= bus_d;
		end
	end

	assign prdata = bus_q.rdata;
	assign pready = bus_q.rdy;
	assign pslverr = bus_q.err;

	apm_mux_core u_mux1 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_sel(w1s),
		.wr_dat(w1d),
		.wr_dir(w1r),
		.wdata(pwdata),
		.pin_in(mux1_pin_in),
		.pin_out(mux1_pin_out),
		.pin_oe(mux1_pin_oe),
		.analog_en(mux1_analog_en),
		.sel_q(sel1),
		.dat_q(dat1),
		.dir_q(dir1),
		.din_q(din1)
	);

	apm_mux_core u_mux2 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_sel(w2s),
		.wr_dat(w2d),
		.wr_dir(w2r),
		.wdata(pwdata),
		.pin_in(mux2_pin_in),
		.pin_out(mux2_pin_out),
		.pin_oe(mux2_pin_oe),
		.analog_en(mux2_analog_en),
		.sel_q(sel2),
		.dat_q(dat2),
		.dir_q(dir2),
		.din_q(din2)
	);
endmodule

//--- shared/apm_pkg.sv
// constants for the analog pin multiplexer pair
package apm_pkg;
	localparam int unsigned PIN_N = 10;
	localparam int unsigned DBIT_N = 4;
	// one odd bit per converter channel, sixteen channels, ten of them pinned
	localparam int unsigned SEL_W = 32;
	// byte offsets of the register sets, one set per multiplexer
	localparam logic [11:0] M1_SEL_OFF = 12'h000;
	localparam logic [11:0] M1_DAT_OFF = 12'h004;
	localparam logic [11:0] M1_DIR_OFF = 12'h008;
	localparam logic [11:0] M2_SEL_OFF = 12'h010;
	localparam logic [11:0] M2_DAT_OFF = 12'h014;
	localparam logic [11:0] M2_DIR_OFF = 12'h018;
	// reset: every odd select bit set, so every pin is analog
	localparam logic [SEL_W-1:0] SEL_RST = 32'hAAAA_AAAA;
	// select bit of each pin slot: twice its converter channel, plus one
	localparam int unsigned SEL_BIT [PIN_N] = '{1, 5, 7, 9, 13, 15, 17, 23, 25, 31};
	localparam logic [DBIT_N-1:0] DAT_RST = 4'h0;
	localparam logic [DBIT_N-1:0] DIR_RST = 4'h0;
	// pin slots that own a digital bit (digital bits 2,4,6,12 / 18,20,22,28)
	localparam int unsigned DPIN0 = 1;
	localparam int unsigned DPIN1 = 3;
	localparam int unsigned DPIN2 = 4;
	localparam int unsigned DPIN3 = 8;
endpackage

//--- hdl/apm_mux_core.sv
`timescale 1ns/1ps
// one analog pin multiplexer: select, data and direction registers plus pin steering
module apm_mux_core
	import apm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_sel,
	input wire logic wr_dat,
	input wire logic wr_dir,
	input wire logic [31:0] wdata,
	input wire logic [PIN_N-1:0] pin_in,
	output logic [PIN_N-1:0] pin_out,
	output logic [PIN_N-1:0] pin_oe,
	output logic [PIN_N-1:0] analog_en,
	output logic [SEL_W-1:0] sel_q,
	output logic [DBIT_N-1:0] dat_q,
	output logic [DBIT_N-1:0] dir_q,
	output logic [DBIT_N-1:0] din_q
);
	localparam int unsigned DPIN [DBIT_N] = '{DPIN0, DPIN1, DPIN2, DPIN3};
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [DBIT_N-1:0] dat;
		logic [DBIT_N-1:0] dir;
		logic [DBIT_N-1:0] s1;
		logic [DBIT_N-1:0] s2;
		logic [PIN_N-1:0] out;
		logic [PIN_N-1:0] oe;
		logic [PIN_N-1:0] ana;
	} apm_core_s;
	apm_core_s st_q, st_d;
	logic [PIN_N-1:0] mode_ana;
	logic [DBIT_N-1:0] din_mask;

	always_comb begin
		st_d = st_q;
		// even select bits are stored for readback only
		if (wr_sel) begin
			st_d.sel = wdata[SEL_W-1:0];
		end
		if (wr_dat) begin
			st_d.dat = wdata[DBIT_N-1:0];
		end
		if (wr_dir) begin
			st_d.dir = wdata[DBIT_N-1:0];
		end
		// pins without a digital bit stay analog whatever their select bit holds
		mode_ana = '1;
		for (int b = 0; b < DBIT_N; b++) begin
			mode_ana[DPIN[b]] = st_q.sel[SEL_BIT[DPIN[b]]];
		end
		st_d.ana = mode_ana;
		st_d.out = '0;
		st_d.oe = '0;
		for (int b = 0; b < DBIT_N; b++) begin
			st_d.s1[b] = pin_in[DPIN[b]];
			st_d.s2[b] = st_q.s1[b];
			// analog mode hides the pin from the digital bit, gated after the synchroniser
			din_mask[b] = ~mode_ana[DPIN[b]];
			st_d.out[DPIN[b]] = st_q.dat[b] & ~mode_ana[DPIN[b]];
			st_d.oe[DPIN[b]] = st_q.dir[b] & ~mode_ana[DPIN[b]];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{sel: SEL_RST, dat: DAT_RST, dir: DIR_RST, s1: '0, s2: '0,
				out: '0, oe: '0, ana: '1};
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_out = st_q.out;
	assign pin_oe = st_q.oe;
	assign analog_en = st_q.ana;
	assign sel_q = st_q.sel;
	assign dat_q = st_q.dat;
	assign dir_q = st_q.dir;
	assign din_q = st_q.s2 & din_mask;
endmodule

//--- tb/apm_chk.sv
// assertions on bus answers and pin steering
`timescale 1ns/1ps
module apm_chk
	import apm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pmaster_ok,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [PIN_N-1:0] mux1_pin_oe,
	input wire logic [PIN_N-1:0] mux1_analog_en,
	input wire logic [PIN_N-1:0] mux2_analog_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic stp = psel && !penable;
	wire logic w1 = stp && pwrite && pmaster_ok && paddr == M1_SEL_OFF;
	wire logic w2 = stp && pwrite && pmaster_ok && paddr == M2_SEL_OFF;
	a_ready_next: assert property (stp |=> pready) else $error("no ready");
	a_ready_once: assert property (pready |=> !pready) else $error("long ready");
	a_refuse_err: assert property (stp && !pmaster_ok |=> pslverr) else $error("no err");
	a_err_zero: assert property (pslverr |-> prdata == '0) else $error("err data");
	a_analog_quiet: assert property ((mux1_analog_en & mux1_pin_oe) == '0) else $error("oe");
	a_no_digital: assert property ((mux1_pin_oe & 10'h2e5) == '0) else $error("slot");
	a_bit5_steer: assert property (w1 |-> ##2 mux1_analog_en[1] == $past(pwdata[5], 2))
		else $error("bit 5");
	a_bit9_steer: assert property (w2 |-> ##2 mux2_analog_en[3] == $past(pwdata[9], 2))
		else $error("bit 9");
	a_reset_analog: assert property ($rose(presetn) |-> &mux1_analog_en && &mux2_analog_en)
		else $error("reset");
	cover property (w1);
	cover property (w2);
	cover property (pslverr);
endmodule
bind apm_pin_mux apm_chk u_chk (.*);

//--- tb/apm_pad_model.sv
// pad model: outside level unless the device drives the pad
`timescale 1ns/1ps
module apm_pad_model
	import apm_pkg::*;
(
	input wire logic [PIN_N-1:0] oe,
	input wire logic [PIN_N-1:0] dout,
	input wire logic [PIN_N-1:0] ext,
	output logic [PIN_N-1:0] pad
);
	// no pull-ups here, so an undriven pad shows only the outside level
	assign pad = (oe & dout) | (~oe & ext);
endmodule

//--- tb/tb_apm_pin_mux.sv
// self-checking bench for the analog pin multiplexer pair
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_apm_pin_mux;
	import apm_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pmaster_ok = 1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, e;
	logic [PIN_N-1:0] mux1_pin_in, mux1_pin_out, mux1_pin_oe, mux1_analog_en, ext1 = '0;
	logic [PIN_N-1:0] mux2_pin_in, mux2_pin_out, mux2_pin_oe, mux2_analog_en, ext2 = '0;
	int err_count = 0, n_compared = 0;
	initial forever #25 pclk = ~pclk;
	apm_pad_model pad1 (.oe(mux1_pin_oe), .dout(mux1_pin_out), .ext(ext1), .pad(mux1_pin_in));
	apm_pad_model pad2 (.oe(mux2_pin_oe), .dout(mux2_pin_out), .ext(ext2), .pad(mux2_pin_in));
	apm_pin_mux DUT (.*);
	task test_done;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 8);
		q = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			err_count++;
			test_done;
		end
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		`CHK(mux1_analog_en & mux2_analog_en, 10'h3ff)
		xfer(0, M1_SEL_OFF, 0);
		`CHK(q, 32'haaaa_aaaa)
		ext2 <= 10'h018;
		xfer(1, M1_SEL_OFF, 32'haaaa_aa8a);
		`CHK(mux1_analog_en, 10'h3fd)
		`CHK(mux2_analog_en, 10'h3ff)
		xfer(0, M2_SEL_OFF, 0);
		`CHK(q, 32'haaaa_aaaa)
		xfer(1, M1_DIR_OFF, 1);
		xfer(1, M1_DAT_OFF, 1);
		`CHK(mux1_pin_out & mux1_pin_oe, 10'h002)
		`CHK(mux2_pin_out | mux2_pin_oe, 10'h000)
		xfer(0, M1_DAT_OFF, 0);
		`CHK(q, 32'h0000_0001)
		xfer(0, M1_DIR_OFF, 0);
		`CHK(q, 32'h0000_0001)
		xfer(1, M2_SEL_OFF, 32'haaaa_a8aa);
		xfer(0, M2_DAT_OFF, 0);
		`CHK(q, 32'h0000_0002)
		`CHK(mux2_pin_oe, 10'h000)
		xfer(1, M2_DIR_OFF, 2);
		xfer(1, M2_DAT_OFF, 2);
		`CHK(mux2_pin_out & mux2_pin_oe, 10'h008)
		xfer(1, M1_SEL_OFF, 32'hffff_ffff);
		`CHK(mux1_analog_en, 10'h3ff)
		`CHK(mux1_pin_oe, 10'h000)
		pmaster_ok <= 0;
		xfer(1, M1_SEL_OFF, 0);
		`CHK(e, 1'b1)
		pmaster_ok <= 1;
		xfer(0, M1_SEL_OFF, 0);
		`CHK(q, 32'hffff_ffff)
		xfer(1, M1_SEL_OFF, 0);
		`CHK(mux1_analog_en, 10'h2e5)
		xfer(0, 12'h00c, 0);
		`CHK({e, q}, 33'h1_0000_0000)
		test_done;
	end
endmodule
